// ==== hdl/lane_hold_pkg.sv ====
// constants for the lane error counter hold register bank
package lane_hold_pkg;
    // lanes served by this bank, first lane number
    localparam int LANES = 3;
    localparam int FIRST_LANE = 2;
    localparam int ERR_KINDS = 3;
    localparam int COUNTERS = LANES * ERR_KINDS;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    // register indices, byte address is four times the index
    localparam logic [13:0] HOLD_IDX_LANE2 = 14'h048A;
    localparam logic [13:0] HOLD_IDX_LANE3 = 14'h048B;
    localparam logic [13:0] HOLD_IDX_LANE4 = 14'h048C;
    localparam logic [13:0] COUNT_IDX_LANE2 = 14'h0500;
    localparam logic [13:0] COUNT_CLEAR_IDX = 14'h0508;
    localparam logic [13:0] IRQ_STATUS_IDX = 14'h0509;
    localparam logic [13:0] IRQ_CLEAR_IDX = 14'h050A;
    localparam logic [13:0] IRQ_ENABLE_IDX = 14'h050B;
    // hold field bits
    localparam int BIT_UNEXPECTED_CTRL = 2;
    localparam int BIT_INVALID_CODE = 1;
    localparam int BIT_DISPARITY = 0;
    localparam logic [2:0] HOLD_RESET = 3'h7;
    localparam logic [7:0] CNT_TERMINAL = 8'hFF;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    // interrupt status layout: one terminal bit per counter, then misuse bit
    localparam int STS_W = 10;
    localparam int STS_MISUSE_BIT = 9;
    localparam logic [9:0] STS_RESET = 10'h000;
    localparam logic [9:0] IEN_RESET = 10'h000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== hdl/lane_error_counter_hold_cfg.sv ====
// hold register bank and error counters for lanes 2 to 4, axi4-lite slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
// Function
// - three error counters per lane, bits 2,1,0
// - hold set: counter stops at 0xFF
// - hold clear: counter rolls over past 0xFF
// - hold fields reset to 0x7
// - per-lane hold registers, upper bits read zero
module lane_error_counter_hold_cfg (
    input  wire logic                                core_clk_i,
    input  wire logic                                rst_b_i,
    input  wire logic [lane_hold_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
    input  wire logic                                s_axi_awvalid_i,
    output logic                                     s_axi_awready_o,
    input  wire logic [lane_hold_pkg::DATA_W-1:0]    s_axi_wdata_i,
    input  wire logic [lane_hold_pkg::STRB_W-1:0]    s_axi_wstrb_i,
    input  wire logic                                s_axi_wvalid_i,
    output logic                                     s_axi_wready_o,
    output logic [1:0]                               s_axi_bresp_o,
    output logic                                     s_axi_bvalid_o,
    input  wire logic                                s_axi_bready_i,
    input  wire logic [lane_hold_pkg::ADDR_W-1:0]    s_axi_araddr_i,
    input  wire logic                                s_axi_arvalid_i,
    output logic                                     s_axi_arready_o,
    output logic [lane_hold_pkg::DATA_W-1:0]         s_axi_rdata_o,
    output logic [1:0]                               s_axi_rresp_o,
    output logic                                     s_axi_rvalid_o,
    input  wire logic                                s_axi_rready_i,
    input  wire logic                                deser_soft_reset_i,
    input  wire logic [2:0]                          lane2_err_i,
    input  wire logic [2:0]                          lane3_err_i,
    input  wire logic [2:0]                          lane4_err_i,
    output logic                                     irq_o
);
    localparam int LN = lane_hold_pkg::LANES;
    localparam int NC = lane_hold_pkg::COUNTERS;
    localparam int SW = lane_hold_pkg::STS_W;

    logic [2:0]                        hold_q [LN];
    logic [lane_hold_pkg::CNT_W-1:0]   cnt_q [NC];
    logic [NC-1:0]                     cnt_clr_q;
    logic [NC-1:0]                     err_evt;
    logic [NC-1:0]                     term_evt;
    logic [SW-1:0]                     sts_q;
    logic [SW-1:0]                     ien_q;
    logic [SW-1:0]                     sts_set;
    logic [SW-1:0]                     sts_clr;
    logic                              irq_q;
    logic                              aw_held_q;
    logic                              w_held_q;
    logic [lane_hold_pkg::ADDR_W-1:0]  waddr_q;
    logic [lane_hold_pkg::DATA_W-1:0]  wdata_q;
    logic [lane_hold_pkg::STRB_W-1:0]  wstrb_q;
    logic                              awready_q;
    logic                              wready_q;
    logic                              bvalid_q;
    logic [1:0]                        bresp_q;
    logic                              arready_q;
    logic                              rvalid_q;
    logic [1:0]                        rresp_q;
    logic [lane_hold_pkg::DATA_W-1:0]  rdata_q;
    logic                              commit;
    logic                              aw_hs;
    logic                              w_hs;
    logic                              ar_hs;
    logic                              aw_held_d;
    logic                              w_held_d;
    logic                              rvalid_d;
    logic [lane_hold_pkg::DATA_W-1:0]  wmask;
    logic [lane_hold_pkg::DATA_W-1:0]  wbits;
    logic [13:0]                       widx;
    logic [LN-1:0]                     hold_hit;
    logic                              wr_hit;
    logic [lane_hold_pkg::DATA_W-1:0]  rd_data;
    logic                              rd_err;
    logic                              first_q;

    assign err_evt = {lane4_err_i, lane3_err_i, lane2_err_i};
    assign aw_hs = s_axi_awvalid_i && awready_q;
    assign w_hs = s_axi_wvalid_i && wready_q;
    assign ar_hs = s_axi_arvalid_i && arready_q;
    // address and data are taken in either order, the write lands once both are held
    assign commit = aw_held_q && w_held_q && !bvalid_q;
    assign aw_held_d = commit ? 1'b0 : (aw_hs ? 1'b1 : aw_held_q);
    assign w_held_d = commit ? 1'b0 : (w_hs ? 1'b1 : w_held_q);
    assign rvalid_d = ar_hs ? 1'b1 : ((rvalid_q && s_axi_rready_i) ? 1'b0 : rvalid_q);
    assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign wbits = wdata_q & wmask;
    assign widx = waddr_q[lane_hold_pkg::ADDR_W-1:2];

    always_comb begin
        wr_hit = 1'b0;
        for (int l = 0; l < LN; l++) begin
            hold_hit[l] = (widx == lane_hold_pkg::HOLD_IDX_LANE2 + 14'(l));
            if (hold_hit[l] || widx == lane_hold_pkg::COUNT_IDX_LANE2 + 14'(l)) begin
                wr_hit = 1'b1;
            end
        end
        if (widx == lane_hold_pkg::COUNT_CLEAR_IDX || widx == lane_hold_pkg::IRQ_STATUS_IDX ||
            widx == lane_hold_pkg::IRQ_CLEAR_IDX || widx == lane_hold_pkg::IRQ_ENABLE_IDX) begin
            wr_hit = 1'b1;
        end
    end

    // write channel capture
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awready_q <= !aw_held_d;
            wready_q <= !w_held_d;
            if (aw_hs) begin
                waddr_q <= s_axi_awaddr_i;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata_i;
                wstrb_q <= s_axi_wstrb_i;
            end
        end
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= lane_hold_pkg::RESP_OKAY;
        end else if (commit) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? lane_hold_pkg::RESP_OKAY : lane_hold_pkg::RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready_i) begin
            bvalid_q <= 1'b0;
        end
    end

    // hold fields, reserved bits are never stored
    for (genvar l = 0; l < LN; l++) begin : g_hold
        always_ff @(posedge core_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                hold_q[l] <= lane_hold_pkg::HOLD_RESET;
            end else if (commit && hold_hit[l] && wstrb_q[0]) begin
                hold_q[l] <= wdata_q[2:0];
            end
        end
    end

    // counter clear strobes, one cycle wide
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_clr_q <= '0;
        end else if (commit && widx == lane_hold_pkg::COUNT_CLEAR_IDX) begin
            cnt_clr_q <= wbits[NC-1:0];
        end else begin
            cnt_clr_q <= '0;
        end
    end

    for (genvar k = 0; k < NC; k++) begin : g_cnt
        localparam int LANE = k / lane_hold_pkg::ERR_KINDS;
        localparam int KIND = k % lane_hold_pkg::ERR_KINDS;
        assign term_evt[k] = err_evt[k] && !cnt_clr_q[k] &&
                             cnt_q[k] == lane_hold_pkg::CNT_TERMINAL - lane_hold_pkg::CNT_ONE;
        always_ff @(posedge core_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                cnt_q[k] <= lane_hold_pkg::CNT_ZERO;
            end else if (cnt_clr_q[k]) begin
                // an error in the clear cycle is counted, not lost
                cnt_q[k] <= err_evt[k] ? lane_hold_pkg::CNT_ONE : lane_hold_pkg::CNT_ZERO;
            end else if (err_evt[k]) begin
                if (cnt_q[k] != lane_hold_pkg::CNT_TERMINAL) begin
                    cnt_q[k] <= cnt_q[k] + lane_hold_pkg::CNT_ONE;
                end else if (!hold_q[LANE][KIND]) begin
                    cnt_q[k] <= lane_hold_pkg::CNT_ZERO;
                end
            end
        end

        a_sat_hold: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            cnt_q[k] == lane_hold_pkg::CNT_TERMINAL && hold_q[LANE][KIND] && !cnt_clr_q[k]
            |=> cnt_q[k] == lane_hold_pkg::CNT_TERMINAL)
            else $error("held counter left terminal value");
        a_wrap_roll: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            cnt_q[k] == lane_hold_pkg::CNT_TERMINAL && !hold_q[LANE][KIND] && err_evt[k]
            && !cnt_clr_q[k] |=> cnt_q[k] == lane_hold_pkg::CNT_ZERO)
            else $error("free counter did not roll over");
        a_count_step: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            cnt_q[k] != lane_hold_pkg::CNT_TERMINAL && err_evt[k] && !cnt_clr_q[k]
            |=> cnt_q[k] == $past(cnt_q[k]) + lane_hold_pkg::CNT_ONE)
            else $error("counter missed an error");
        a_clear_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
            cnt_clr_q[k] && !err_evt[k] |=> cnt_q[k] == lane_hold_pkg::CNT_ZERO)
            else $error("cleared counter not zero");
    end

    // interrupt status: hardware set beats software clear
    always_comb begin
        sts_set = '0;
        sts_set[NC-1:0] = term_evt;
        // a hold write outside soft reset is flagged, the write still lands
        sts_set[lane_hold_pkg::STS_MISUSE_BIT] = commit && (|hold_hit) && !deser_soft_reset_i;
        sts_clr = '0;
        if (commit && widx == lane_hold_pkg::IRQ_CLEAR_IDX) begin
            sts_clr = wbits[SW-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sts_q <= lane_hold_pkg::STS_RESET;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ien_q <= lane_hold_pkg::IEN_RESET;
        end else if (commit && widx == lane_hold_pkg::IRQ_ENABLE_IDX) begin
            ien_q <= (ien_q & ~wmask[SW-1:0]) | wbits[SW-1:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_q & ien_q);
        end
    end

    // read decode, unmapped addresses answer slverr with zero data
    always_comb begin
        rd_data = '0;
        rd_err = 1'b1;
        for (int l = 0; l < LN; l++) begin
            if (s_axi_araddr_i[15:2] == lane_hold_pkg::HOLD_IDX_LANE2 + 14'(l)) begin
                rd_data = {29'h0, hold_q[l]};
                rd_err = 1'b0;
            end
            if (s_axi_araddr_i[15:2] == lane_hold_pkg::COUNT_IDX_LANE2 + 14'(l)) begin
                rd_data = {8'h00, cnt_q[3 * l + 2], cnt_q[3 * l + 1], cnt_q[3 * l]};
                rd_err = 1'b0;
            end
        end
        if (s_axi_araddr_i[15:2] == lane_hold_pkg::IRQ_STATUS_IDX) begin
            rd_data = {22'h0, sts_q};
            rd_err = 1'b0;
        end
        if (s_axi_araddr_i[15:2] == lane_hold_pkg::IRQ_ENABLE_IDX) begin
            rd_data = {22'h0, ien_q};
            rd_err = 1'b0;
        end
        // write-only registers read as zero
        if (s_axi_araddr_i[15:2] == lane_hold_pkg::IRQ_CLEAR_IDX ||
            s_axi_araddr_i[15:2] == lane_hold_pkg::COUNT_CLEAR_IDX) begin
            rd_err = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= lane_hold_pkg::RESP_OKAY;
            rdata_q <= '0;
        end else begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_hs) begin
                rdata_q <= rd_data;
                rresp_q <= rd_err ? lane_hold_pkg::RESP_SLVERR : lane_hold_pkg::RESP_OKAY;
            end
        end
    end

    assign s_axi_awready_o = awready_q;
    assign s_axi_wready_o = wready_q;
    assign s_axi_bvalid_o = bvalid_q;
    assign s_axi_bresp_o = bresp_q;
    assign s_axi_arready_o = arready_q;
    assign s_axi_rvalid_o = rvalid_q;
    assign s_axi_rresp_o = rresp_q;
    assign s_axi_rdata_o = rdata_q;
    assign irq_o = irq_q;

    // helper: low only in the first cycle after reset release
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_q <= 1'b0;
        end else begin
            first_q <= 1'b1;
        end
    end

    sequence s_hold3_read;
        ar_hs && s_axi_araddr_i[15:2] == lane_hold_pkg::HOLD_IDX_LANE3;
    endsequence

    sequence s_hold4_read;
        ar_hs && s_axi_araddr_i[15:2] == lane_hold_pkg::HOLD_IDX_LANE4;
    endsequence

    a_hold_reset: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !first_q |-> hold_q[0] == 3'h7 && hold_q[1] == 3'h7 && hold_q[2] == 3'h7)
        else $error("hold fields not 0x7 after reset");
    a_hold3_map: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_hold3_read |=> rvalid_q && rresp_q == 2'h0 && rdata_q == {29'h0, $past(hold_q[1])})
        else $error("lane 3 hold read wrong");
    a_hold4_map: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_hold4_read |=> rvalid_q && rdata_q[31:3] == 29'h0 && rdata_q[2:0] == $past(hold_q[2]))
        else $error("lane 4 hold read wrong");
    a_misuse_flag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        commit && (|hold_hit) && !deser_soft_reset_i |=> sts_q[lane_hold_pkg::STS_MISUSE_BIT])
        else $error("hold write outside soft reset not flagged");
    a_bad_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        commit && !wr_hit |=> s_axi_bvalid_o && s_axi_bresp_o == 2'h2)
        else $error("unmapped write not refused");
    a_irq_level: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ##1 irq_o == |($past(sts_q) & $past(ien_q)))
        else $error("interrupt level wrong");

endmodule // lane_error_counter_hold_cfg

// ==== bench/lane_err_source.sv ====
// far-side model: transmitter whose lanes raise error pulses
`timescale 1ns/10ps
module lane_err_source (
    input  wire logic       core_clk_i,
    output logic [2:0]      lane2_err_o,
    output logic [2:0]      lane3_err_o,
    output logic [2:0]      lane4_err_o
);
    initial begin
        lane2_err_o = 3'h0;
        lane3_err_o = 3'h0;
        lane4_err_o = 3'h0;
    end

    // one error per cycle on each kind in the mask, all kinds in the same cycles, other lanes held at zero
    task automatic burst(input int lane, input logic [2:0] kinds, input int n);
        logic [2:0] m;
        m = 3'h0;
        for (int i = 0; i <= n; i++) begin
            @(posedge core_clk_i);
            m = (i < n) ? kinds : 3'h0;
            lane2_err_o <= (lane == 2) ? m : 3'h0;
            lane3_err_o <= (lane == 3) ? m : 3'h0;
            lane4_err_o <= (lane == 4) ? m : 3'h0;
        end
    endtask
endmodule // lane_err_source

// ==== bench/tb_lane_error_counter_hold_cfg.sv ====
// register-level testbench for the lane error counter hold bank
`timescale 1ns/10ps
module tb_lane_error_counter_hold_cfg;
    logic        core_clk_i = 1'b0;
    logic        rst_b_i    = 1'b0;
    logic [15:0] awaddr     = 16'h0000;
    logic        awvalid    = 1'b0;
    logic [31:0] wdata      = 32'h0000_0000;
    logic        wvalid     = 1'b0;
    logic        bready     = 1'b0;
    logic [15:0] araddr     = 16'h0000;
    logic        arvalid    = 1'b0;
    logic        rready     = 1'b0;
    logic        soft_rst   = 1'b1;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [2:0]  err2, err3, err4;
    int          failures = 0;
    int          checks   = 0;
    int          cycles   = 0;

    always #12.5 core_clk_i = ~core_clk_i;

    lane_err_source i_lane_err_source (.core_clk_i(core_clk_i), .lane2_err_o(err2),
        .lane3_err_o(err3), .lane4_err_o(err4));

    lane_error_counter_hold_cfg i_lane_error_counter_hold_cfg (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .deser_soft_reset_i(soft_rst),
        .lane2_err_i(err2), .lane3_err_i(err3), .lane4_err_i(err4), .irq_o(irq));

    task automatic stop_test;
        if (failures == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // no test needs more than a few thousand cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [13:0] idx, input logic [31:0] data);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge core_clk_i);
        awaddr <= {idx, 2'b00};
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge core_clk_i);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk_i); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd_reg(input logic [13:0] idx);
        @(posedge core_clk_i);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge core_clk_i);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        for (int i = 0; i < 3; i++) begin
            rd_reg(lane_hold_pkg::HOLD_IDX_LANE2 + 14'(i));
            check("hold reset", rd, 32'h0000_0007);
            rd_reg(lane_hold_pkg::COUNT_IDX_LANE2 + 14'(i));
            check("count reset", rd, 32'h0000_0000);
        end
        // programmed only while the deserializer is held in soft reset
        wr(lane_hold_pkg::HOLD_IDX_LANE3, 32'hFFFF_FFFA);
        check("hold wr resp", 32'(resp), 32'h0);
        rd_reg(lane_hold_pkg::HOLD_IDX_LANE3);
        check("hold lane3", rd, 32'h0000_0002);
        rd_reg(14'h0400);
        check("unmapped rd", rd, 32'h0);
        check("unmapped rresp", 32'(resp), 32'(lane_hold_pkg::RESP_SLVERR));
        wr(14'h0400, 32'h1);
        check("unmapped wr", 32'(resp), 32'h2);
        rd_reg(lane_hold_pkg::IRQ_STATUS_IDX);
        check("no misuse", rd, 32'h0);
        soft_rst <= 1'b0;
        // lane2 holds all kinds, lane3 wraps all but invalid code
        i_lane_err_source.burst(2, 3'h7, 300);
        i_lane_err_source.burst(3, 3'h7, 257);
        rd_reg(lane_hold_pkg::COUNT_IDX_LANE2);
        check("lane2 held", rd, 32'h00FF_FFFF);
        rd_reg(lane_hold_pkg::COUNT_IDX_LANE2 + 14'h1);
        check("lane3 mixed", rd, 32'h0001_FF01);
        rd_reg(lane_hold_pkg::IRQ_STATUS_IDX);
        check("status", rd, 32'h0000_003F);
        check("irq masked", 32'(irq), 32'h0);
        wr(lane_hold_pkg::IRQ_ENABLE_IDX, 32'h8);
        rd_reg(lane_hold_pkg::IRQ_ENABLE_IDX);
        check("irq enable", rd, 32'h0000_0008);
        repeat (2) @(posedge core_clk_i);
        check("irq on", 32'(irq), 32'h1);
        wr(lane_hold_pkg::IRQ_CLEAR_IDX, 32'h8);
        repeat (2) @(posedge core_clk_i);
        check("irq cleared", 32'(irq), 32'h0);
        rd_reg(lane_hold_pkg::IRQ_STATUS_IDX);
        check("status clr", rd, 32'h0000_0037);
        // clearing a held counter lets it count again
        wr(lane_hold_pkg::COUNT_CLEAR_IDX, 32'h11);
        rd_reg(lane_hold_pkg::COUNT_IDX_LANE2);
        check("lane2 clr", rd, 32'h00FF_FF00);
        rd_reg(lane_hold_pkg::COUNT_IDX_LANE2 + 14'h1);
        check("lane3 clr", rd, 32'h0001_0001);
        i_lane_err_source.burst(2, 3'h1, 1);
        rd_reg(lane_hold_pkg::COUNT_IDX_LANE2);
        check("lane2 resume", rd, 32'h00FF_FF01);
        // a write outside soft reset is flagged
        wr(lane_hold_pkg::HOLD_IDX_LANE4, 32'h3);
        rd_reg(lane_hold_pkg::IRQ_STATUS_IDX);
        check("misuse flag", rd, 32'h0000_0237);
        rd_reg(lane_hold_pkg::HOLD_IDX_LANE4);
        check("hold lane4", rd, 32'h0000_0003);
        stop_test;
    end
endmodule // tb_lane_error_counter_hold_cfg
